//--- design/stn_display_drive_control.sv
// stn display drive control: register file, mux and line rate, power sequence, drivers
// assumes an axi4-lite master on aclk; display memory pixel arrives on mem_pixel
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module stn_display_drive_control import stn_drive_pkg::*; #(
    parameter int BASE_DIV = 64,
    parameter int ROWS = 160
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // display memory path
    input wire logic [15:0] mem_pixel,
    input wire logic [11:0] host_pixel_12,
    output logic [15:0] mem_write_pixel,
    // panel drive
    output logic [ROWS-1:0] row_drive,
    output logic [15:0] column_data,
    output logic column_tie,
    output logic sleep_mode,
    output logic supply_enable,
    output drive_setting_t drive_setting,
    output logic [8:0] mux_rate,
    output logic line_pulse
);
    // refuse sizes the row decode and period counters cannot hold
    if (ROWS != 160 || BASE_DIV < 2 || BASE_DIV > 8191) begin
        $error("unsupported parameters");
    end

    logic [8:0] line_config_reg;
    logic [7:0] row_end_index_reg, partial_start_row_reg, partial_end_row_reg;
    logic [7:0] fixed_lines_top_reg, fixed_lines_bottom_reg, scroll_line_reg;
    logic [12:0] power_control_reg;
    logic [2:0] display_control_reg;
    logic [7:0] win_start_col_reg, win_end_col_reg;
    logic aw_held_reg, w_held_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic bvalid_reg, rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] bresp_reg, rresp_reg;

    // write channel: address and data taken independently, response after both
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire have_aw = aw_held_reg || aw_fire;
    wire have_w = w_held_reg || w_fire;
    wire do_write = have_aw && have_w && !bvalid_reg;
    wire [7:0] wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
    wire [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
    wire wr_low = wr_addr[1:0] == 2'h0 && wr_addr <= ADDR_DRIVE;
    wire wr_hit = wr_low && wr_addr != ADDR_STATUS;
    wire wr_en = do_write && wr_hit && s_axi_wstrb != 4'h0;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
        end else begin
            if (aw_fire && !do_write) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held_reg <= 1'b0;
            end
            if (w_fire && !do_write) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
            end else if (do_write) begin
                w_held_reg <= 1'b0;
            end
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_config_reg <= LINE_CFG_RESET;
            row_end_index_reg <= ROW_END_RESET;
            partial_start_row_reg <= 8'h00;
            partial_end_row_reg <= ROW_END_RESET;
            fixed_lines_top_reg <= 8'h00;
            fixed_lines_bottom_reg <= 8'h00;
            scroll_line_reg <= 8'h00;
            power_control_reg <= 13'h0;
            display_control_reg <= 3'h0;
            win_start_col_reg <= 8'h00;
            win_end_col_reg <= MAX_COLUMN;
        end else if (wr_en) begin
            case (wr_addr)
                ADDR_LINE_CFG: line_config_reg <= wr_data[8:0];
                ADDR_ROWS: begin
                    row_end_index_reg <= wr_data[7:0];
                    partial_start_row_reg <= wr_data[15:8];
                    partial_end_row_reg <= wr_data[23:16];
                    scroll_line_reg <= wr_data[31:24];
                end
                ADDR_FIXED: begin
                    fixed_lines_top_reg <= wr_data[7:0];
                    fixed_lines_bottom_reg <= wr_data[15:8];
                end
                ADDR_POWER: power_control_reg <= wr_data[12:0];
                ADDR_DISPLAY: display_control_reg <= wr_data[2:0];
                ADDR_WINDOW: begin
                    win_start_col_reg <= wr_data[7:0];
                    win_end_col_reg <= wr_data[15:8];
                end
                default: ;
            endcase
        end
    end

    // multiplex rate
    wire partial_en = line_config_reg[CFG_PARTIAL_EN];
    wire fixed_incl = line_config_reg[CFG_FIXED_INCL];
    wire [8:0] fixed_sum = 9'(fixed_lines_top_reg) + 9'(fixed_lines_bottom_reg);
    wire [8:0] partial_span = 9'(partial_end_row_reg) - 9'(partial_start_row_reg) + 9'd1;
    wire [8:0] fixed_extra = fixed_incl ? 9'(fixed_sum << 1) : 9'd0;
    wire [8:0] mux_next = partial_en ? 9'(partial_span + fixed_extra)
                                     : 9'(row_end_index_reg) + 9'd1;
    assign mux_rate = mux_next;

    // line rate scaling in half steps
    wire [1:0] rate_sel = line_config_reg[CFG_RATE_LO +: 2];
    wire shade_onoff = line_config_reg[CFG_SHADE_ONOFF];
    wire [3:0] mux_scale = (mux_next <= MUX_40) ? SCALE_4 :
                           (mux_next <= MUX_56) ? SCALE_3 :
                           (mux_next <= MUX_80) ? SCALE_2 :
                           (mux_next <= MUX_108) ? SCALE_1P5 : SCALE_1;
    wire [15:0] base_period = 16'(BASE_DIV) << rate_sel;
    wire [19:0] scaled_half = 20'(base_period) * 20'(mux_scale);
    wire [19:0] onoff_extra = shade_onoff ? 20'(SCALE_ONOFF) : 20'd1;
    wire [20:0] line_period = 21'((scaled_half >> 1) * onoff_extra);

    // power sequence
    pwr_state_t pwr_reg, pwr_next;
    logic [7:0] seq_cnt_reg;
    wire display_enable_flag = display_control_reg[2];
    wire seq_done = seq_cnt_reg == 8'd0;
    always_comb begin
        pwr_next = pwr_reg;
        case (pwr_reg)
            PWR_SLEEP: if (display_enable_flag) pwr_next = PWR_WAKE;
            PWR_WAKE: begin
                if (!display_enable_flag) pwr_next = PWR_SLEEP;
                else if (seq_done) pwr_next = PWR_SUPPLY;
            end
            PWR_SUPPLY: begin
                if (!display_enable_flag) pwr_next = PWR_SLEEP;
                else if (seq_done) pwr_next = PWR_ACTIVE;
            end
            PWR_ACTIVE: if (!display_enable_flag) pwr_next = PWR_SLEEP;
            default: pwr_next = PWR_SLEEP;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwr_reg <= PWR_SLEEP;
            seq_cnt_reg <= 8'd0;
        end else begin
            pwr_reg <= pwr_next;
            if (pwr_next != pwr_reg) begin
                seq_cnt_reg <= (pwr_next == PWR_WAKE) ? 8'(WAKE_CYC - 1) : 8'(SUPPLY_CYC - 1);
            end else if (!seq_done) begin
                seq_cnt_reg <= seq_cnt_reg - 8'd1;
            end
        end
    end
    wire drivers_on = pwr_reg == PWR_ACTIVE;

    // line counter and row scan
    logic [20:0] div_cnt_reg;
    logic [8:0] line_cnt_reg;
    logic line_pulse_reg;
    wire line_tick = div_cnt_reg + 21'd1 >= line_period;
    always_ff @(posedge aclk) begin
        if (!aresetn || !drivers_on) begin
            div_cnt_reg <= 21'd0;
            line_cnt_reg <= 9'd0;
            line_pulse_reg <= 1'b0;
        end else begin
            line_pulse_reg <= line_tick;
            div_cnt_reg <= line_tick ? 21'd0 : div_cnt_reg + 21'd1;
            // a shrunken mux rate restarts the scan at once
            if (line_cnt_reg >= mux_next) begin
                line_cnt_reg <= 9'd0;
            end else if (line_tick) begin
                line_cnt_reg <= (line_cnt_reg + 9'd1 >= mux_next) ? 9'd0
                                                                  : line_cnt_reg + 9'd1;
            end
        end
    end
    assign line_pulse = line_pulse_reg;

    // row index within scan and window of enabled rows
    wire [8:0] top_end = 9'(fixed_lines_top_reg);
    wire [8:0] scan_row = partial_en ? 9'(line_cnt_reg + 9'(partial_start_row_reg))
                                     : line_cnt_reg;
    wire row_ok = scan_row < ROW_COUNT && scan_row <= 9'(row_end_index_reg);
    logic [ROWS-1:0] row_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            row_reg <= '0;
        end else begin
            row_reg <= '0;
            if (drivers_on && row_ok) begin
                row_reg[scan_row[7:0]] <= 1'b1;
            end
        end
    end
    assign row_drive = row_reg;

    // memory row to read: fixed regions ignore scroll
    wire [8:0] bot_start = 9'(row_end_index_reg) + 9'd1 - 9'(fixed_lines_bottom_reg);
    wire in_fixed = scan_row < top_end || scan_row >= bot_start;
    wire [8:0] scrolled = 9'(scan_row + 9'(scroll_line_reg));
    wire [8:0] mem_row = in_fixed ? scan_row
                       : (scrolled >= ROW_COUNT ? 9'(scrolled - ROW_COUNT) : scrolled);

    // column output: enable overrides all-on and inverse
    wire all_pixels_on_flag = display_control_reg[1];
    wire inverse_display_flag = display_control_reg[0];
    logic [15:0] col_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn || !drivers_on) begin
            col_reg <= 16'h0;
        end else if (all_pixels_on_flag) begin
            col_reg <= 16'hffff;
        end else begin
            col_reg <= inverse_display_flag ? ~mem_pixel : mem_pixel;
        end
    end
    assign column_data = col_reg;
    assign column_tie = !drivers_on;
    assign sleep_mode = pwr_reg == PWR_SLEEP;
    assign supply_enable = pwr_reg == PWR_SUPPLY || drivers_on;

    // drive voltage setting
    assign drive_setting.bias_ratio_code = power_control_reg[3:2];
    assign drive_setting.potentiometer_value = power_control_reg[11:4];
    assign drive_setting.temp_coefficient_code = power_control_reg[12] ? 2'h0
                                                 : power_control_reg[1:0];
    assign drive_setting.pump_internal = !power_control_reg[12];

    // colour conversion
    wire [1:0] colour_mode = line_config_reg[CFG_COLOUR_LO +: 2];
    wire [15:0] ext12 = {host_pixel_12[11:8], host_pixel_12[11], host_pixel_12[7:4],
                         host_pixel_12[7:6], host_pixel_12[3:0], host_pixel_12[3]};
    assign mem_write_pixel = (colour_mode == COLOUR_12BIT) ? ext12
                           : {4'h0, host_pixel_12};

    // mirrored window column bounds
    wire col_mirror = line_config_reg[CFG_COL_MIRROR];
    wire [7:0] win_lo = col_mirror ? 8'(MAX_COLUMN - win_start_col_reg) : win_start_col_reg;
    wire [7:0] win_hi = col_mirror ? 8'(MAX_COLUMN - win_end_col_reg) : win_end_col_reg;

    // read channel
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    wire rd_low = s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= ADDR_DRIVE;
    logic [31:0] rd_mux;
    always_comb begin
        case (s_axi_araddr)
            ADDR_LINE_CFG: rd_mux = {23'h0, line_config_reg};
            ADDR_ROWS: rd_mux = {scroll_line_reg, partial_end_row_reg,
                                 partial_start_row_reg, row_end_index_reg};
            ADDR_FIXED: rd_mux = {16'h0, fixed_lines_bottom_reg, fixed_lines_top_reg};
            ADDR_POWER: rd_mux = {19'h0, power_control_reg};
            ADDR_DISPLAY: rd_mux = {29'h0, display_control_reg};
            ADDR_WINDOW: rd_mux = {win_hi, win_lo, win_end_col_reg, win_start_col_reg};
            ADDR_STATUS: rd_mux = {3'h0, mem_row, mux_next, line_cnt_reg, pwr_reg};
            ADDR_DRIVE: rd_mux = {19'h0, drive_setting};
            default: rd_mux = 32'h0;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= 2'h0;
        end else if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_low ? rd_mux : 32'h0;
            rresp_reg <= rd_low ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // checks
    property p_mux_partial;
        @(posedge aclk) disable iff (!aresetn)
        partial_en && fixed_incl |-> mux_rate == 9'(partial_span + 9'(fixed_sum << 1));
    endproperty
    a_mux_partial: assert property (p_mux_partial) else $error("partial mux wrong");
    property p_mux_full;
        @(posedge aclk) disable iff (!aresetn)
        !partial_en |-> mux_rate == 9'(row_end_index_reg) + 9'd1;
    endproperty
    a_mux_full: assert property (p_mux_full) else $error("full mux wrong");
    property p_sleep_on_clear;
        @(posedge aclk) disable iff (!aresetn)
        !display_enable_flag ##1 !display_enable_flag |=> sleep_mode && column_tie
            && row_drive == '0;
    endproperty
    a_sleep_on_clear: assert property (p_sleep_on_clear) else $error("no sleep");
    property p_wake_order;
        @(posedge aclk) disable iff (!aresetn)
        $rose(supply_enable) |-> !drivers_on ##1 !drivers_on;
    endproperty
    a_wake_order: assert property (p_wake_order) else $error("drivers before supply");
    property p_all_on;
        @(posedge aclk) disable iff (!aresetn)
        drivers_on && all_pixels_on_flag && $past(drivers_on)
            |=> column_data == 16'hffff || !$past(all_pixels_on_flag);
    endproperty
    a_all_on: assert property (p_all_on) else $error("all-on not forced");
    property p_inverse;
        @(posedge aclk) disable iff (!aresetn)
        drivers_on && !all_pixels_on_flag && inverse_display_flag ##1 drivers_on
            |-> column_data == ~$past(mem_pixel);
    endproperty
    a_inverse: assert property (p_inverse) else $error("inverse wrong");
    property p_idle_blank;
        @(posedge aclk) disable iff (!aresetn)
        !drivers_on |=> column_data == 16'h0;
    endproperty
    a_idle_blank: assert property (p_idle_blank) else $error("idle columns driven");
    property p_line_wrap;
        @(posedge aclk) disable iff (!aresetn)
        line_cnt_reg < mux_rate || $changed(mux_rate) || !drivers_on;
    endproperty
    a_line_wrap: assert property (p_line_wrap) else $error("line count past mux");
    property p_mirror;
        @(posedge aclk) disable iff (!aresetn)
        col_mirror |-> win_lo + win_start_col_reg == MAX_COLUMN;
    endproperty
    a_mirror: assert property (p_mirror) else $error("mirror bound wrong");
    property p_mirror_end;
        @(posedge aclk) disable iff (!aresetn)
        col_mirror |-> 8'(MAX_COLUMN - win_hi) == win_end_col_reg;
    endproperty
    a_mirror_end: assert property (p_mirror_end) else $error("mirror end wrong");
    property p_leave_sleep_first;
        @(posedge aclk) disable iff (!aresetn)
        $rose(supply_enable) |-> !$past(sleep_mode);
    endproperty
    a_leave_sleep_first: assert property (p_leave_sleep_first) else $error("supply in sleep");
    property p_one_row;
        @(posedge aclk) disable iff (!aresetn)
        $onehot0(row_drive);
    endproperty
    a_one_row: assert property (p_one_row) else $error("several rows driven");
endmodule

//--- design/stn_drive_pkg.sv
// package for the stn display drive control block: register map, fields, timing
// assumes a 32-bit axi4-lite master and a 250 MHz aclk
// How it works
// - mux rate from row end, partial, fixed lines
// - partial mux: end-start+1 plus twice fixed lines
// - bias code 0..3 gives 5,10,11,12
// - temp code picks 0,-0.05,-0.15,-0.25 %/C
// - power bit picks internal pump or external
// - internal drive setting from bias, pot, temp
// - two-bit line rate; frame = line/mux
// - low mux divides line rate 1.5,2,3,4
// - on/off shade mode lowers line rate
// - enable bit idles drivers, columns tied together
// - clearing enable idles drivers and sleeps
// - enabling: wake, restore supplies, then drivers
// - enable overrides all-on and inverse
// - all-on forces column on, memory untouched
// - inverse outputs inverted memory data
// - row driver x always drives row x
// - fixed top/bottom rows ignore scroll offset
// - shade mode switch leaves memory untouched
// - 12-bit colour extended to 5-6-5
// - 16-bit colour zero-extends host_pixel_12, default after reset
// - mirrored window columns are 127 minus bounds
package stn_drive_pkg;
    localparam logic [7:0] ADDR_LINE_CFG = 8'h00;
    localparam logic [7:0] ADDR_ROWS = 8'h04;
    localparam logic [7:0] ADDR_FIXED = 8'h08;
    localparam logic [7:0] ADDR_POWER = 8'h0c;
    localparam logic [7:0] ADDR_DISPLAY = 8'h10;
    localparam logic [7:0] ADDR_WINDOW = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_DRIVE = 8'h1c;
    // line config fields
    localparam int CFG_FIXED_INCL = 0;
    localparam int CFG_COL_MIRROR = 1;
    localparam int CFG_ROW_MIRROR = 2;
    localparam int CFG_RATE_LO = 3;
    localparam int CFG_SHADE_ONOFF = 5;
    localparam int CFG_COLOUR_LO = 6;
    localparam int CFG_PARTIAL_EN = 8;
    localparam logic [1:0] COLOUR_12BIT = 2'h1;
    localparam logic [1:0] COLOUR_16BIT = 2'h2;
    localparam logic [8:0] LINE_CFG_RESET = 9'h080;
    localparam logic [7:0] ROW_END_RESET = 8'h9f;
    localparam logic [7:0] MAX_COLUMN = 8'h7f;
    localparam logic [8:0] ROW_COUNT = 9'd160;
    // mux thresholds and line rate base dividers (in units of half a step)
    localparam logic [8:0] MUX_108 = 9'd108;
    localparam logic [8:0] MUX_80 = 9'd80;
    localparam logic [8:0] MUX_56 = 9'd56;
    localparam logic [8:0] MUX_40 = 9'd40;
    localparam logic [3:0] SCALE_1 = 4'd2;
    localparam logic [3:0] SCALE_1P5 = 4'd3;
    localparam logic [3:0] SCALE_2 = 4'd4;
    localparam logic [3:0] SCALE_3 = 4'd6;
    localparam logic [3:0] SCALE_4 = 4'd8;
    localparam logic [3:0] SCALE_ONOFF = 4'd2;
    // wake sequence times
    localparam int CLK_MHZ = 250;
    localparam int WAKE_NS = 100;
    localparam int SUPPLY_NS = 200;
    localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
    localparam int SUPPLY_CYC = (SUPPLY_NS * CLK_MHZ + 999) / 1000;
    typedef enum logic [1:0] {
        PWR_SLEEP = 2'b00,
        PWR_WAKE = 2'b01,
        PWR_SUPPLY = 2'b10,
        PWR_ACTIVE = 2'b11
    } pwr_state_t;
    typedef struct packed {
        logic [1:0] bias_ratio_code;
        logic [7:0] potentiometer_value;
        logic [1:0] temp_coefficient_code;
        logic pump_internal;
    } drive_setting_t;
endpackage

//--- verification/stn_display_drive_control_tb.sv
// testbench for the stn display drive control block
// assumes the design runs with BASE_DIV 2 so line periods are a few cycles
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module stn_display_drive_control_tb import stn_drive_pkg::*; ;
    logic aclk = 0, aresetn = 0, clr = 1;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdv;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rrs;
    logic [15:0] mem_pixel = 16'h1234, mem_write_pixel, column_data;
    logic [11:0] host_pixel_12 = 12'hb6d;
    logic [159:0] row_drive;
    logic column_tie, sleep_mode, supply_enable, line_pulse, multi_hot;
    drive_setting_t drive_setting;
    logic [8:0] mux_rate;
    int row_min, row_max, num_errors = 0, tests_run = 0;

    stn_display_drive_control #(.BASE_DIV(2)) u_stn_display_drive_control (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_pixel, .host_pixel_12,
        .mem_write_pixel, .row_drive, .column_data, .column_tie, .sleep_mode,
        .supply_enable, .drive_setting, .mux_rate, .line_pulse);
    stn_panel_model u_stn_panel_model (.aclk, .clr, .row_drive, .multi_hot, .row_min,
        .row_max);

    initial begin
        forever #2 aclk = ~aclk;
    end

    task automatic conclude;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic tmo;
        num_errors++;
        $display("CHECK FAILED wait bound exp 1 got 0");
        conclude();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (n == 50) tmo();
        s_axi_bready <= 1'b0;
        `CHK("bresp", er, s_axi_bresp);
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (n == 50) tmo();
        s_axi_rready <= 1'b0;
        rdv = s_axi_rdata;
        rrs = s_axi_rresp;
    endtask

    // cycles between the second and third line pulse seen
    task automatic per(output int p);
        int n;
        int k;
        p = 0;
        k = 0;
        for (n = 0; n < 300; n++) begin
            @(posedge aclk);
            if (line_pulse) k++;
            if (k == 3) break;
            if (k == 2) p++;
        end
        if (n == 300) tmo();
    endtask

    task automatic t_regs;
        `CHK("reset mux", 9'd160, mux_rate);
        `CHK("reset tie", 1'b1, column_tie);
        `CHK("reset sleep", 1'b1, sleep_mode);
        rd(ADDR_LINE_CFG);
        `CHK("line cfg reset", 32'h080, rdv);
        rd(ADDR_ROWS);
        `CHK("rows reset", 32'h009f009f, rdv);
        rd(8'h40);
        `CHK("unmapped resp", 2'h2, rrs);
        `CHK("unmapped data", 32'h0, rdv);
        wr(ADDR_STATUS, 32'h1, 2'h2);
        `CHK("direct pixel", {4'h0, 12'hb6d}, mem_write_pixel);
        wr(ADDR_LINE_CFG, 32'h042, 2'h0);
        `CHK("red msbs", 4'hb, mem_write_pixel[15:12]);
        `CHK("green msbs", 4'h6, mem_write_pixel[10:7]);
        `CHK("blue msbs", 4'hd, mem_write_pixel[4:1]);
        wr(ADDR_WINDOW, 32'h2005, 2'h0);
        rd(ADDR_WINDOW);
        `CHK("mirror start", 8'h7a, rdv[23:16]);
        `CHK("mirror end", 8'h5f, rdv[31:24]);
        wr(ADDR_FIXED, 32'h0302, 2'h0);
        wr(ADDR_ROWS, 32'h052f109f, 2'h0);
        rd(ADDR_STATUS);
        `CHK("fixed row unscrolled", 9'd0, rdv[28:20]);
        wr(ADDR_LINE_CFG, 32'h180, 2'h0);
        rd(ADDR_STATUS);
        `CHK("scrolled row", 9'd21, rdv[28:20]);
        wr(ADDR_LINE_CFG, 32'h080, 2'h0);
    endtask

    task automatic t_power;
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_POWER, 32'h0a50 | (k << 2) | k, 2'h0);
            `CHK("bias", 2'(k), drive_setting.bias_ratio_code);
            `CHK("temp", 2'(k), drive_setting.temp_coefficient_code);
            `CHK("pot", 8'ha5, drive_setting.potentiometer_value);
            `CHK("pump", 1'b1, drive_setting.pump_internal);
        end
        wr(ADDR_POWER, 32'h1a5f, 2'h0);
        `CHK("external", 1'b0, drive_setting.pump_internal);
    endtask

    task automatic t_enable;
        int n;
        wr(ADDR_DISPLAY, 32'h4, 2'h0);
        for (n = 0; n < 300 && !supply_enable; n++) @(posedge aclk);
        if (n == 300) tmo();
        `CHK("awake at supply", 1'b0, sleep_mode);
        `CHK("tied at supply", 1'b1, column_tie);
        for (n = 0; n < 300 && column_tie; n++) @(posedge aclk);
        if (n == 300) tmo();
        `CHK("drivers after supply", 1'b1, 1'(n == SUPPLY_CYC));
    endtask

    task automatic t_disp;
        repeat (4) @(posedge aclk);
        `CHK("memory data", 16'h1234, column_data);
        wr(ADDR_DISPLAY, 32'h5, 2'h0);
        repeat (3) @(posedge aclk);
        `CHK("inverse", 16'hedcb, column_data);
        wr(ADDR_DISPLAY, 32'h6, 2'h0);
        repeat (3) @(posedge aclk);
        `CHK("all on", 16'hffff, column_data);
        wr(ADDR_DISPLAY, 32'h3, 2'h0);
        repeat (3) @(posedge aclk);
        `CHK("disabled data", 16'h0, column_data);
        `CHK("disabled tie", 1'b1, column_tie);
        `CHK("disabled sleep", 1'b1, sleep_mode);
        `CHK("disabled rows", 160'h0, row_drive);
    endtask

    task automatic t_rate;
        int p;
        int mux_set[6] = '{108, 109, 80, 56, 40, 41};
        int sc[6] = '{3, 2, 4, 6, 8, 6};
        for (int r = 0; r < 4; r++) begin
            wr(ADDR_LINE_CFG, 32'h080 | (r << 3), 2'h0);
            per(p);
            `CHK("line period", 2 << r, p);
        end
        wr(ADDR_LINE_CFG, 32'h0a0, 2'h0);
        per(p);
        `CHK("on off period", 4, p);
        wr(ADDR_LINE_CFG, 32'h180, 2'h0);
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_ROWS, {8'h0, 8'(15 + mux_set[i]), 16'h109f}, 2'h0);
            `CHK("partial mux", 9'(mux_set[i]), mux_rate);
            per(p);
            `CHK("scaled period", sc[i], p);
        end
        wr(ADDR_FIXED, 32'h0302, 2'h0);
        wr(ADDR_ROWS, 32'h002f109f, 2'h0);
        wr(ADDR_LINE_CFG, 32'h181, 2'h0);
        `CHK("fixed mux", 9'd42, mux_rate);
        rd(ADDR_STATUS);
        `CHK("status mux", 9'd42, rdv[19:11]);
        wr(ADDR_LINE_CFG, 32'h180, 2'h0);
        // let the stale row from the wider scan drain first
        repeat (2) @(posedge aclk);
        clr <= 1'b0;
        repeat (600) @(posedge aclk);
        `CHK("first row", 16, row_min);
        `CHK("last row", 47, row_max);
        `CHK("one row", 1'b0, multi_hot);
    endtask

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_power();
        t_enable();
        t_disp();
        t_enable();
        t_rate();
        conclude();
    end
endmodule

//--- verification/stn_panel_model.sv
// panel electrode model: watches the row scan and records which rows it reached
// assumes the bench pulses clr before each observation window
`timescale 1ns/10ps
module stn_panel_model (
    // clock and control
    input wire logic aclk,
    input wire logic clr,
    // row electrodes
    input wire logic [159:0] row_drive,
    // observations
    output logic multi_hot,
    output int row_min,
    output int row_max
);
    always_ff @(posedge aclk) begin
        if (clr) begin
            multi_hot <= 1'b0;
            row_min <= 999;
            row_max <= -1;
        end else begin
            // two rows selected together would load the panel wrongly
            if ($countones(row_drive) > 1) multi_hot <= 1'b1;
            for (int i = 0; i < 160; i++) begin
                if (row_drive[i] && i < row_min) row_min <= i;
                if (row_drive[i] && i > row_max) row_max <= i;
            end
        end
    end
endmodule
